// >>> shared/autoneg_pkg.sv
// Constants for the auto-negotiation register set
// How it works
// [R01] Five 16-bit registers, same index on pages 0, 1 and 2.
// [R02] Page select register chooses which page software accesses.
// [R03] Advertise bits 8..5 are writable ability bits, reset to one.
// [R04] Advertise bits 4:0 writable selector, reset 00001.
// [R05] Advertise bits 11 and 10 writable pause bits, reset zero.
// [R06] Advertise 15 next page, 13 remote fault writable; 14,12,9 reserved.
// [R07] Partner ability resets zero; bit 14 sets on link code word receipt. The code copies bit 14 from base_page_word and does not force it.
// [R08] Partner bits 11,10 pause; bits 8..5 speed and duplex abilities.
// [R09] Partner bit 9 reports partner T4 ability though unsupported locally.
// [R10] Partner bits 4:0 selector, zero before any page received.
// [R11] Expansion bit 4 latches parallel detection fault until read.
// [R12] Expansion bit 1 latches page received until read.
// [R13] Expansion bit 2 reads one; bits 3 and 0 partner abilities.
// [R14] Next page out writable: 15 more, 13 message, 12 comply, 10:0 code.
// [R15] Next page out bit 11 reads inverse of last sent toggle.
// [R16] Received next page read-only, reset zero, all partner fields.
// [R17] Received next page bit 12 is partner comply flag.
// [R18] Reserved and read-only bits ignore writes; reserved read zero.
package autoneg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_ADV      = 8'h04;
	localparam logic [7:0]  IDX_LPA      = 8'h05;
	localparam logic [7:0]  IDX_EXP      = 8'h06;
	localparam logic [7:0]  IDX_NP_OUT   = 8'h07;
	localparam logic [7:0]  IDX_LP_NP    = 8'h08;
	localparam logic [7:0]  IDX_PAGE     = 8'h1F;
	localparam logic [7:0]  IDX_IRQ_STAT = 8'h20;
	localparam logic [7:0]  IDX_IRQ_MASK = 8'h21;
	localparam logic [1:0]  PAGE_MAX     = 2'h2;
	// Reset values and writable masks
	localparam logic [15:0] ADV_RST      = 16'h01E1;
	localparam logic [15:0] ADV_WMASK    = 16'hADFF;
	localparam logic [15:0] NP_OUT_RST   = 16'h2001;
	localparam logic [15:0] NP_OUT_WMASK = 16'hB7FF;
	localparam int          EXP_PDF_BIT  = 4;
	localparam int          EXP_LPNP_BIT = 3;
	localparam int          EXP_NPA_BIT  = 2;
	localparam int          EXP_PR_BIT   = 1;
	localparam int          EXP_LPAN_BIT = 0;
	localparam int          NP_TOG_BIT   = 11;
	localparam logic [15:0] LPA_VMASK    = 16'hEFFF;
	// Interrupt status bits: 0 page received, 1 parallel fault
	localparam logic [1:0]  IRQ_RST      = 2'h0;
	localparam logic [1:0]  BRESP_OK     = 2'h0;
	localparam logic [1:0]  BRESP_SLVERR = 2'h2;
endpackage

// >>> hw/phy_autoneg_register_set.sv
// Auto-negotiation register set with an AXI4-Lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module phy_autoneg_register_set
	import autoneg_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [9:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [9:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        base_page_valid,
	input  wire logic [15:0] base_page_word,
	input  wire logic        next_page_valid,
	input  wire logic [15:0] next_page_word,
	input  wire logic        parallel_fault,
	input  wire logic        partner_an_able,
	input  wire logic        next_page_sent,
	input  wire logic        sent_toggle,
	output logic [15:0]      adv_word,
	output logic [15:0]      next_page_out_word,
	output logic             irq
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [15:0] adv_q, lpa_q, np_out_q, lp_np_q;
	logic        exp_pdf_q, exp_pr_q, exp_lpan_q, tog_q;
	logic [1:0]  page_q, irq_stat_q, irq_mask_q;
	logic        aw_hold_q, w_hold_q;
	logic [7:0]  aw_idx_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        do_write, do_read, rd_ok;
	logic [15:0] wval, rd_val;
	logic [7:0]  ar_idx;

	// ----------------------------------------
	// Write channel capture, either order
	// ----------------------------------------
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	assign wval     = {(wstrb_q[1] ? wdata_q[15:8] : 8'h00), (wstrb_q[0] ? wdata_q[7:0] : 8'h00)};
	// Partial strobes keep the other byte of the stored value
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] msk);
		logic [15:0] byte_m;
		byte_m = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & msk;
		merge  = (old & ~byte_m) | (wval & byte_m);
	endfunction

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			aw_hold_q     <= 1'b0;
			w_hold_q      <= 1'b0;
			aw_idx_q      <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= BRESP_OK;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q     <= 1'b1;
				aw_idx_q      <= s_axi_awaddr[9:2];
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q     <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok(aw_idx_q) ? BRESP_OK : BRESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Mapped indices; the five auto-negotiation words need a valid page
	function automatic logic wr_ok(input logic [7:0] idx);
		wr_ok = ((idx >= IDX_ADV && idx <= IDX_LP_NP) && page_q <= PAGE_MAX) // [R01]
			|| idx == IDX_PAGE || idx == IDX_IRQ_STAT || idx == IDX_IRQ_MASK;
	endfunction

	// ----------------------------------------
	// Page select and software-written words
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			page_q     <= 2'h0;
			adv_q      <= ADV_RST;    // [R03] [R04] [R05] [R06]
			np_out_q   <= NP_OUT_RST; // [R14]
			irq_mask_q <= IRQ_RST;
		end else if (do_write && wr_ok(aw_idx_q)) begin
			case (aw_idx_q)
				IDX_PAGE:     if (wstrb_q[0]) page_q <= wval[1:0]; // [R02]
				IDX_ADV:      adv_q <= merge(adv_q, ADV_WMASK); // [R03] [R04] [R05] [R06] [R18]
				IDX_NP_OUT:   np_out_q <= merge(np_out_q, NP_OUT_WMASK); // [R14] [R18]
				IDX_IRQ_MASK: if (wstrb_q[0]) irq_mask_q <= wval[1:0];
				default:      ;
			endcase
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	assign ar_idx  = s_axi_araddr[9:2];
	assign do_read = s_axi_arvalid && s_axi_arready;
	assign rd_ok   = wr_ok(ar_idx);

	always_comb begin
		rd_val = 16'h0000; // [R18]
		case (ar_idx)
			IDX_ADV:      rd_val = adv_q & ADV_WMASK; // [R06]
			IDX_LPA:      rd_val = lpa_q; // [R07] [R08] [R09] [R10]
			IDX_EXP: begin
				rd_val[EXP_PDF_BIT]  = exp_pdf_q;  // [R11]
				rd_val[EXP_LPNP_BIT] = lpa_q[15];  // [R13]
				rd_val[EXP_NPA_BIT]  = 1'b1;       // [R13]
				rd_val[EXP_PR_BIT]   = exp_pr_q;   // [R12]
				rd_val[EXP_LPAN_BIT] = exp_lpan_q; // [R13]
			end
			IDX_NP_OUT: begin
				rd_val             = np_out_q;
				rd_val[NP_TOG_BIT] = !tog_q; // [R15]
			end
			IDX_LP_NP:    rd_val = lp_np_q; // [R16] [R17]
			IDX_PAGE:     rd_val = {14'h0000, page_q};
			IDX_IRQ_STAT: rd_val = {14'h0000, irq_stat_q};
			IDX_IRQ_MASK: rd_val = {14'h0000, irq_mask_q};
			default:      rd_val = 16'h0000;
		endcase
		if (!rd_ok) rd_val = 16'h0000;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= BRESP_OK;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (do_read) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {16'h0000, rd_val};
				s_axi_rresp   <= rd_ok ? BRESP_OK : BRESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Expansion register read clears its latched-high flags
	logic exp_read;
	assign exp_read = do_read && ar_idx == IDX_EXP && rd_ok;

	// ----------------------------------------
	// Partner pages from the negotiation engine
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lpa_q   <= 16'h0000; // [R07] [R10]
			lp_np_q <= 16'h0000; // [R16]
		end else begin
			// Bit 12 is reserved; everything else mirrors the base page
			if (base_page_valid) lpa_q <= base_page_word & LPA_VMASK; // [R07] [R08] [R09] [R10]
			// Comply flag in bit 12 is carried through unchanged
			if (next_page_valid) lp_np_q <= next_page_word; // [R16] [R17]
		end
	end

	// Latched-high flags: a new event in the read cycle wins over the clear
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			exp_pdf_q  <= 1'b0;
			exp_pr_q   <= 1'b0;
			exp_lpan_q <= 1'b0;
		end else begin
			exp_pdf_q  <= parallel_fault || (exp_pdf_q && !exp_read); // [R11]
			exp_pr_q   <= base_page_valid || next_page_valid
				|| (exp_pr_q && !exp_read); // [R12]
			exp_lpan_q <= partner_an_able; // [R13]
		end
	end

	// Toggle of the last link code word sent
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tog_q <= 1'b1;
		end else if (next_page_sent) begin
			tog_q <= sent_toggle; // [R15]
		end
	end

	// ----------------------------------------
	// Interrupt: sticky status, write one to clear, set wins
	// ----------------------------------------
	logic [1:0] irq_ev, irq_clr;
	assign irq_ev  = {parallel_fault, base_page_valid || next_page_valid};
	assign irq_clr = (do_write && aw_idx_q == IDX_IRQ_STAT && wstrb_q[0]) ? wval[1:0] : 2'h0;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq_stat_q <= IRQ_RST;
			irq        <= 1'b0;
		end else begin
			irq_stat_q <= irq_ev | (irq_stat_q & ~irq_clr);
			irq        <= |((irq_ev | (irq_stat_q & ~irq_clr)) & irq_mask_q);
		end
	end

	// Outputs toward the negotiation engine, straight from flip-flops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			adv_word           <= ADV_RST;
			next_page_out_word <= NP_OUT_RST;
		end else begin
			adv_word           <= adv_q & ADV_WMASK;
			// Bit 11 carries the inverse of the last sent toggle, as software reads it
			next_page_out_word <= {np_out_q[15:12], !tog_q, np_out_q[10:0]}; // [R15]
		end
	end
endmodule
`default_nettype wire

// >>> tb/autoneg_monitor.sv
// Port checks for the auto-negotiation register set
`timescale 1ns/100ps
`default_nettype none
module autoneg_checker
	import autoneg_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        next_page_sent,
	input wire logic        sent_toggle,
	input wire logic [15:0] adv_word,
	input wire logic [15:0] next_page_out_word
);
	// One clock domain, so clock and reset are given once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	a_adv_reset: assert property ($rose(rst_n) |-> adv_word == ADV_RST)
		else $error("advertise reset value wrong");
	a_np_reset: assert property ($rose(rst_n) |-> next_page_out_word == NP_OUT_RST)
		else $error("next page reset value wrong");
	a_adv_reserved: assert property ((adv_word & ~ADV_WMASK) == 16'h0000)
		else $error("advertise reserved bit set");
	a_toggle_shown: assert property (next_page_sent |-> ##2 next_page_out_word[11] == !$past(sent_toggle, 2))
		else $error("toggle not inverted");
endmodule
bind phy_autoneg_register_set autoneg_checker u_autoneg_checker (.*);
`default_nettype wire

// >>> tb/autoneg_link_partner.sv
// Remote partner model: received pages and link events
`timescale 1ns/100ps
`default_nettype none
module autoneg_link_partner (
	input  wire logic        ref_clk,
	output logic             base_page_valid,
	output logic [15:0]      base_page_word,
	output logic             next_page_valid,
	output logic [15:0]      next_page_word,
	output logic             parallel_fault,
	output logic             partner_an_able,
	output logic             next_page_sent,
	output logic             sent_toggle
);
	// Quiet link at time zero
	initial begin
		{base_page_valid, next_page_valid, parallel_fault, partner_an_able} = '0;
		{next_page_sent, base_page_word, next_page_word, sent_toggle} = '0;
	end
	// One-cycle event; words flip afterwards so stale data never passes as fresh
	task automatic send(input int k, input logic [15:0] w);
		@(posedge ref_clk);
		base_page_word <= w;
		next_page_word <= w;
		sent_toggle <= w[11];
		base_page_valid <= (k == 0);
		partner_an_able <= partner_an_able | (k == 0);
		next_page_valid <= (k == 1);
		parallel_fault <= (k == 2);
		next_page_sent <= (k == 3);
		@(posedge ref_clk);
		{base_page_valid, next_page_valid, parallel_fault, next_page_sent} <= '0;
		base_page_word <= ~w;
		next_page_word <= ~w;
		sent_toggle <= ~w[11];
	endtask
endmodule
`default_nettype wire

// >>> tb/phy_autoneg_register_set_test.sv
// Testbench for the auto-negotiation register set
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module phy_autoneg_register_set_test
	import autoneg_pkg::*;
;
	logic        ref_clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic [9:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = '0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        base_page_valid, next_page_valid, parallel_fault, partner_an_able;
	logic        next_page_sent, sent_toggle;
	logic [15:0] base_page_word, next_page_word, adv_word, next_page_out_word, v, ea;
	logic [33:0] rq[$], er;
	logic [1:0]  bq[$], eb;
	int          n_errors = 0, checks_done = 0, sd;
	phy_autoneg_register_set u_phy_autoneg_register_set (.*);
	autoneg_link_partner u_autoneg_link_partner (.*);
	initial forever #2.5 ref_clk = ~ref_clk;
	// -------------------------------------------------
	// Bus tasks; each notes its expected answer first
	// -------------------------------------------------
	task automatic rd(input logic [7:0] i, input logic [1:0] r, input logic [15:0] d);
		rq.push_back({r, 16'h0000, d});
		@(posedge ref_clk);
		s_axi_araddr <= {i, 2'b00};
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [1:0] e);
		bit a, w;
		bq.push_back(e);
		@(posedge ref_clk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		{a, w} = 2'b11;
		do begin
			@(posedge ref_clk);
			a = a & (s_axi_awready !== 1'b1);
			w = w & (s_axi_wready !== 1'b1);
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end while (a | w);
		while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic end_sim;
		$display("Checks %0d, errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Oldest note against each answer as it appears
	always @(posedge ref_clk) begin
		if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
			er = rq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, er)
		end
		if (s_axi_bvalid && s_axi_bready && bq.size() > 0) begin
			eb = bq.pop_front();
			`CHK(s_axi_bresp, eb)
		end
	end
	// Hang guard at 10000 cycles, far beyond the few hundred cycles the run needs
	initial begin
		#50000;
		n_errors++;
		end_sim();
	end
	// Main sequence
	initial begin
		sd = $urandom(32'h55d8_4d10);
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(IDX_ADV, BRESP_OK, ADV_RST);
		rd(IDX_LPA, BRESP_OK, 16'h0000);
		rd(IDX_EXP, BRESP_OK, 16'h0004);
		rd(IDX_NP_OUT, BRESP_OK, NP_OUT_RST);
		rd(IDX_LP_NP, BRESP_OK, 16'h0000);
		repeat (4) begin
			v = 16'($urandom);
			ea = v & ADV_WMASK;
			wr(IDX_ADV, v, BRESP_OK);
			rd(IDX_ADV, BRESP_OK, ea);
			`CHK(adv_word, ea)
		end
		wr(IDX_NP_OUT, 16'hffff, BRESP_OK);
		rd(IDX_NP_OUT, BRESP_OK, 16'hb7ff);
		u_autoneg_link_partner.send(3, 16'h0000);
		rd(IDX_NP_OUT, BRESP_OK, 16'hbfff);
		wr(IDX_IRQ_MASK, 16'h0001, BRESP_OK);
		v = 16'($urandom) | 16'h4000;
		u_autoneg_link_partner.send(0, v);
		rd(IDX_LPA, BRESP_OK, v & LPA_VMASK);
		`CHK(irq, 1'b1)
		rd(IDX_EXP, BRESP_OK, {12'h000, v[15], 3'b111});
		rd(IDX_EXP, BRESP_OK, {12'h000, v[15], 3'b101});
		wr(IDX_IRQ_STAT, 16'h0001, BRESP_OK);
		u_autoneg_link_partner.send(2, 16'h0000);
		`CHK(irq, 1'b0)
		rd(IDX_EXP, BRESP_OK, {11'h000, 1'b1, v[15], 3'b101});
		rd(IDX_EXP, BRESP_OK, {12'h000, v[15], 3'b101});
		wr(IDX_IRQ_MASK, 16'h0003, BRESP_OK);
		// Interrupt follows the mask one cycle after the write lands
		@(posedge ref_clk);
		`CHK(irq, 1'b1)
		wr(IDX_IRQ_STAT, 16'h0002, BRESP_OK);
		@(posedge ref_clk);
		`CHK(irq, 1'b0)
		v = 16'($urandom);
		u_autoneg_link_partner.send(1, v);
		wr(IDX_PAGE, 16'h0002, BRESP_OK);
		rd(IDX_LP_NP, BRESP_OK, v);
		wr(IDX_PAGE, 16'h0003, BRESP_OK);
		wr(IDX_ADV, 16'h0000, BRESP_SLVERR);
		rd(IDX_ADV, BRESP_SLVERR, 16'h0000);
		wr(IDX_PAGE, 16'h0001, BRESP_OK);
		rd(IDX_ADV, BRESP_OK, ea);
		rd(8'h10, BRESP_SLVERR, 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire
